// >>> design/sri_sfr_init.sv
// Purpose: Special function register bank with per-class initialisation
// Assumes: All inputs synchronous to i_ref_clk; single whole-word AHB-Lite transfers
// Notes: Reads take one wait state so a preceding write is always visible
//
// The address map and the AHB-Lite register port were chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

module sri_sfr_init (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire sri_pkg::sri_ahb_req_t i_ahb,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire sri_pkg::sri_class_ev_t i_class_ev,
  input wire sri_pkg::sri_cond_t i_cond,
  input wire sri_pkg::sri_wake_t i_wake,
  input wire logic [20:0] i_pc,
  input wire logic i_osc_frees_pins,
  input wire logic [7:0] i_port_a_pins,
  output logic o_irq,
  output logic o_pc_load,
  output logic [20:0] o_pc_vector,
  output logic [7:0] o_port_a_latch,
  output logic [7:0] o_port_a_direction,
  output logic o_port_a_hi_en
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] apply_val(input logic [7:0] cur, input logic [7:0] load,
                                           input logic [7:0] val, input logic [7:0] qm,
                                           input logic [7:0] qin);
    logic [7:0] tmp;
    tmp = (cur & ~load) | (val & load);
    return (tmp & ~qm) | (qin & qm);
  endfunction

  function automatic logic [7:0] qmask_of(input logic [6:0] idx, input sri_pkg::sri_cls_t cls);
    logic [7:0] m;
    m = 8'h00;
    if (idx == sri_pkg::SRI_IDX_OSC) begin
      case (cls)
        sri_pkg::SRI_CLS_POR: m = sri_pkg::SRI_OSC_Q_POR;
        sri_pkg::SRI_CLS_RST: m = sri_pkg::SRI_OSC_Q_RST;
        sri_pkg::SRI_CLS_WAKE: m = sri_pkg::SRI_OSC_Q_WAKE;
        default: m = 8'h00;
      endcase
    end else if (idx == sri_pkg::SRI_IDX_RSTC) begin
      case (cls)
        sri_pkg::SRI_CLS_POR: m = sri_pkg::SRI_RSTC_Q_POR;
        sri_pkg::SRI_CLS_RST: m = sri_pkg::SRI_RSTC_Q_RST;
        sri_pkg::SRI_CLS_WAKE: m = sri_pkg::SRI_RSTC_Q_WAKE;
        default: m = 8'h00;
      endcase
    end
    return m;
  endfunction

  function automatic logic [7:0] qin_of(input logic [6:0] idx, input sri_pkg::sri_cond_t c);
    logic [7:0] q;
    q = 8'h00;
    if (idx == sri_pkg::SRI_IDX_OSC) begin
      q = c.osc_q;
    end else if (idx == sri_pkg::SRI_IDX_RSTC) begin
      q = c.rstc_q;
    end
    return q;
  endfunction

  // ----------------------------------------------------------------
  // Bus slave front end
  // ----------------------------------------------------------------
  logic acc;
  logic rd_pend_r;
  logic wr_pend_r;
  logic [6:0] addr_r;
  logic addr_ok_r;
  logic [7:0] wdata;
  logic [7:0] rd_val;

  assign acc = i_ahb.hsel & i_ahb.htrans[1] & i_ahb.hready;
  assign wdata = i_ahb.hwdata[7:0];

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rd_pend_r <= 1'b0;
      wr_pend_r <= 1'b0;
      addr_r <= 7'h00;
      addr_ok_r <= 1'b0;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      rd_pend_r <= acc & ~i_ahb.hwrite;
      wr_pend_r <= acc & i_ahb.hwrite;
      if (acc) begin
        addr_r <= i_ahb.haddr[8:2];
        addr_ok_r <= (i_ahb.haddr[31:9] == 23'h000000);
      end
      // One wait state on reads: data is sampled after any earlier write lands
      o_hreadyout <= ~(acc & ~i_ahb.hwrite);
      o_hresp <= 1'b0;
    end
  end

  logic wr_hit;
  logic rd_hit;
  assign wr_hit = wr_pend_r & addr_ok_r;
  assign rd_hit = rd_pend_r & addr_ok_r;

  // ----------------------------------------------------------------
  // Class decode
  // ----------------------------------------------------------------
  logic cls_por;
  logic cls_rst;
  logic cls_wake;
  logic vec_take;
  assign cls_por = ~i_rst_n | (i_class_ev.valid & (i_class_ev.cls == sri_pkg::SRI_CLS_POR));
  assign cls_rst = i_rst_n & i_class_ev.valid & (i_class_ev.cls == sri_pkg::SRI_CLS_RST);
  assign cls_wake = i_rst_n & i_class_ev.valid & (i_class_ev.cls == sri_pkg::SRI_CLS_WAKE);
  // The enable that matches the waking interrupt's priority decides vectoring
  assign vec_take = cls_wake & i_wake.by_int &
                    (i_wake.high_prio ? i_wake.high_global_int_enable : i_wake.low_global_int_enable);

  // ----------------------------------------------------------------
  // Table-driven register bank
  // ----------------------------------------------------------------
  logic [7:0] sfr_r [0:sri_pkg::SRI_NUM_SFR-1];

  always_ff @(posedge i_ref_clk) begin
    for (int i = 0; i < sri_pkg::SRI_NUM_SFR; i++) begin
      if (cls_por) begin
        // Undefined contents are given zero so simulation stays known
        sfr_r[i] <= apply_val(sfr_r[i], sri_pkg::SRI_IMPL[i], sri_pkg::SRI_POR_VAL[i],
                              qmask_of(7'(i), sri_pkg::SRI_CLS_POR), qin_of(7'(i), i_cond));
      end else if (cls_rst) begin
        sfr_r[i] <= apply_val(sfr_r[i], sri_pkg::SRI_RST_LOAD[i], sri_pkg::SRI_RST_VAL[i],
                              qmask_of(7'(i), sri_pkg::SRI_CLS_RST), qin_of(7'(i), i_cond));
      end else if (cls_wake) begin
        sfr_r[i] <= apply_val(sfr_r[i], sri_pkg::SRI_WAKE_LOAD[i], sri_pkg::SRI_WAKE_VAL[i],
                              qmask_of(7'(i), sri_pkg::SRI_CLS_WAKE), qin_of(7'(i), i_cond));
      end else if (wr_hit && addr_r == 7'(i)) begin
        sfr_r[i] <= wdata & sri_pkg::SRI_IMPL[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Return stack top, pointer and vector
  // ----------------------------------------------------------------
  logic [20:0] tos_r;
  logic [7:0] stk_r;

  always_ff @(posedge i_ref_clk) begin
    if (cls_por) begin
      tos_r <= 21'h000000;
      stk_r <= 8'h00;
    end else if (cls_rst) begin
      tos_r <= 21'h000000;
      stk_r <= stk_r & sri_pkg::SRI_STK_KEEP_RST;
    end else if (vec_take) begin
      tos_r <= i_pc;
      stk_r <= {stk_r[7:5], stk_r[4:0] + 5'h01};
    end else if (wr_hit) begin
      case (addr_r)
        sri_pkg::SRI_IDX_TOS_UPPER: tos_r[20:16] <= wdata[4:0];
        sri_pkg::SRI_IDX_TOS_HIGH: tos_r[15:8] <= wdata;
        sri_pkg::SRI_IDX_TOS_LOW: tos_r[7:0] <= wdata;
        sri_pkg::SRI_IDX_STKP: stk_r <= wdata & sri_pkg::SRI_STK_IMPL;
        default: tos_r <= tos_r;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_pc_load <= 1'b0;
      o_pc_vector <= 21'h000000;
    end else begin
      o_pc_load <= vec_take;
      if (vec_take) begin
        o_pc_vector <= i_wake.high_prio ? sri_pkg::SRI_VEC_HIGH : sri_pkg::SRI_VEC_LOW;
      end
    end
  end

  // ----------------------------------------------------------------
  // Port A and wake flags
  // ----------------------------------------------------------------
  logic [7:0] pa_latch_r;
  logic [7:0] pa_dir_r;
  logic [7:0] pa_mask;
  logic [7:0] int_flags_r;
  assign pa_mask = i_osc_frees_pins ? sri_pkg::SRI_PA_ALL : sri_pkg::SRI_PA_LOW6;

  always_ff @(posedge i_ref_clk) begin
    if (cls_por) begin
      pa_latch_r <= 8'h00;
      pa_dir_r <= sri_pkg::SRI_PA_DIR_RST;
    end else if (cls_rst) begin
      pa_dir_r <= sri_pkg::SRI_PA_DIR_RST;
    end else if (wr_hit && addr_r == sri_pkg::SRI_IDX_PA_LATCH) begin
      pa_latch_r <= wdata & pa_mask;
    end else if (wr_hit && addr_r == sri_pkg::SRI_IDX_PA_DIR) begin
      pa_dir_r <= wdata & pa_mask;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_port_a_latch <= 8'h00;
      o_port_a_direction <= 8'h00;
      o_port_a_hi_en <= 1'b0;
    end else begin
      o_port_a_latch <= pa_latch_r & pa_mask;
      o_port_a_direction <= pa_dir_r & pa_mask;
      o_port_a_hi_en <= i_osc_frees_pins;
    end
  end

  // A software write never hides the flag that the waking event sets
  always_ff @(posedge i_ref_clk) begin
    if (cls_por || cls_rst) begin
      int_flags_r <= 8'h00;
    end else begin
      int_flags_r <= ((wr_hit && addr_r == sri_pkg::SRI_IDX_INT_FLAGS) ? wdata : int_flags_r) |
                     (cls_wake ? i_wake.src : 8'h00);
    end
  end

  // ----------------------------------------------------------------
  // Event status, mask and interrupt
  // ----------------------------------------------------------------
  logic [3:0] irq_status_r;
  logic [3:0] irq_mask_r;
  logic [3:0] ev;
  logic st_rd_clr;

  always_comb begin
    ev = 4'h0;
    ev[sri_pkg::SRI_EV_POR] = i_rst_n & cls_por;
    ev[sri_pkg::SRI_EV_RST] = cls_rst;
    ev[sri_pkg::SRI_EV_WAKE] = cls_wake;
    ev[sri_pkg::SRI_EV_VEC] = vec_take;
  end

  assign st_rd_clr = rd_hit & (addr_r == sri_pkg::SRI_IDX_IRQ_STATUS);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      irq_status_r <= 4'h0;
      irq_mask_r <= 4'h0;
      o_irq <= 1'b0;
    end else begin
      // Set wins over the clear-on-read in the same cycle
      irq_status_r <= (st_rd_clr ? 4'h0 : irq_status_r) | ev;
      if (wr_hit && addr_r == sri_pkg::SRI_IDX_IRQ_MASK) begin
        irq_mask_r <= wdata[3:0];
      end
      o_irq <= |(irq_status_r & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 8'h00;
    if (!addr_ok_r) begin
      rd_val = 8'h00;
    end else if (addr_r < 7'(sri_pkg::SRI_NUM_SFR)) begin
      rd_val = sfr_r[addr_r[4:0]] & sri_pkg::SRI_IMPL[addr_r[4:0]];
    end else begin
      case (addr_r)
        sri_pkg::SRI_IDX_TOS_UPPER: rd_val = {3'h0, tos_r[20:16]};
        sri_pkg::SRI_IDX_TOS_HIGH: rd_val = tos_r[15:8];
        sri_pkg::SRI_IDX_TOS_LOW: rd_val = tos_r[7:0];
        sri_pkg::SRI_IDX_STKP: rd_val = stk_r & sri_pkg::SRI_STK_IMPL;
        sri_pkg::SRI_IDX_PA_LATCH: rd_val = pa_latch_r & pa_mask;
        sri_pkg::SRI_IDX_PA_DIR: rd_val = pa_dir_r & pa_mask;
        sri_pkg::SRI_IDX_PA_PINS: rd_val = i_port_a_pins & pa_mask;
        sri_pkg::SRI_IDX_INT_FLAGS: rd_val = int_flags_r;
        sri_pkg::SRI_IDX_IRQ_STATUS: rd_val = {4'h0, irq_status_r};
        sri_pkg::SRI_IDX_IRQ_MASK: rd_val = {4'h0, irq_mask_r};
        default: rd_val = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_hrdata <= 32'h00000000;
    end else if (rd_pend_r) begin
      o_hrdata <= {24'h000000, rd_val};
    end
  end

endmodule

`default_nettype wire

// >>> design/sri_pkg.sv
// Purpose: Constants and carrier types for the reset-class register bank
// Assumes: One 40 MHz core clock; registers reached over AHB-Lite, one per word
// Notes: Per-register value tables are indexed by the register index
//
// Behaviour
// - Pointer-2 low, timer0 low, timer1 high/low and the serial buffer are undefined at power-on and held otherwise.
// - Timer0 high, timer2 count, serial address, serial state and both serial controls clear on both resets, hold on wake.
// - Timer0 control loads all ones on both resets and holds on wake; timer2 period loads all ones in every class.
// - Oscillator control loads 0100 q000 on both resets and on wake keeps all bits but a condition-set bit 1.
// - Voltage detect control loads 0-00 0101 on both resets and holds on wake.
// - Reset cause control takes 0q-1 11q0 at power-on, 0q-q qquu on other resets and uq-u qquu on wake.
// - Timer2 control clears bits 6:0 on both resets and keeps them on wake, bit 7 being unimplemented.
// - The five status flags are undefined at power-on and kept across other resets and wake.
// - Every unimplemented bit reads as zero in every class.
// - An interrupt wake with the matching global enable set loads the program counter with 0008h or 0018h.
// - Such a wake copies the current program counter into the three top-of-return-stack bytes.
// - Such a wake advances the return stack pointer to the next stack location.
// - Port A bits 6 and 7 of data, latch and direction read as zero unless the oscillator mode frees them.
// - A wake leaves at least one interrupt flag bit set that records its cause.

package sri_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int SRI_NUM_SFR = 24;
  localparam logic [6:0] SRI_IDX_OSC = 7'h09;
  localparam logic [6:0] SRI_IDX_RSTC = 7'h0C;
  localparam logic [6:0] SRI_IDX_TOS_UPPER = 7'h18;
  localparam logic [6:0] SRI_IDX_TOS_HIGH = 7'h19;
  localparam logic [6:0] SRI_IDX_TOS_LOW = 7'h1A;
  localparam logic [6:0] SRI_IDX_STKP = 7'h1B;
  localparam logic [6:0] SRI_IDX_PA_LATCH = 7'h1C;
  localparam logic [6:0] SRI_IDX_PA_DIR = 7'h1D;
  localparam logic [6:0] SRI_IDX_PA_PINS = 7'h1E;
  localparam logic [6:0] SRI_IDX_INT_FLAGS = 7'h1F;
  localparam logic [6:0] SRI_IDX_IRQ_STATUS = 7'h20;
  localparam logic [6:0] SRI_IDX_IRQ_MASK = 7'h21;

  // ----------------------------------------------------------------
  // Per-register tables, index 0 to 23
  // ----------------------------------------------------------------
  typedef logic [7:0] sri_tab_t [0:SRI_NUM_SFR-1];
  localparam sri_tab_t SRI_IMPL = '{8'h0F, 8'hFF, 8'h0F, 8'h0F, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hBF,
    8'h01, 8'hDF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam sri_tab_t SRI_POR_VAL = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h40, 8'h05,
    8'h00, 8'h1C, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam sri_tab_t SRI_RST_LOAD = '{8'h0F, 8'h00, 8'h0F, 8'h0F, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hBF,
    8'h01, 8'hDC, 8'h00, 8'h00, 8'h40, 8'hFF, 8'hFF, 8'h7F, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam sri_tab_t SRI_RST_VAL = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h40, 8'h05,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam sri_tab_t SRI_WAKE_LOAD = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00,
    8'h00, 8'h4C, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam sri_tab_t SRI_WAKE_VAL = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // Condition-dependent bit positions per class
  localparam logic [7:0] SRI_OSC_Q_POR = 8'h08;
  localparam logic [7:0] SRI_OSC_Q_RST = 8'h08;
  localparam logic [7:0] SRI_OSC_Q_WAKE = 8'h02;
  localparam logic [7:0] SRI_RSTC_Q_POR = 8'h42;
  localparam logic [7:0] SRI_RSTC_Q_RST = 8'h5C;
  localparam logic [7:0] SRI_RSTC_Q_WAKE = 8'h4C;

  // ----------------------------------------------------------------
  // Other fields and values
  // ----------------------------------------------------------------
  localparam logic [7:0] SRI_STK_IMPL = 8'hDF;
  localparam logic [7:0] SRI_STK_KEEP_RST = 8'hC0;
  localparam logic [7:0] SRI_PA_ALL = 8'hFF;
  localparam logic [7:0] SRI_PA_LOW6 = 8'h3F;
  localparam logic [7:0] SRI_PA_DIR_RST = 8'hFF;
  localparam logic [20:0] SRI_VEC_HIGH = 21'h000008;
  localparam logic [20:0] SRI_VEC_LOW = 21'h000018;
  localparam int SRI_EV_POR = 0;
  localparam int SRI_EV_RST = 1;
  localparam int SRI_EV_WAKE = 2;
  localparam int SRI_EV_VEC = 3;

  typedef enum logic [2:0] {
    SRI_CLS_POR = 3'b001,
    SRI_CLS_RST = 3'b010,
    SRI_CLS_WAKE = 3'b100
  } sri_cls_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } sri_ahb_req_t;

  typedef struct packed {
    logic valid;
    sri_cls_t cls;
  } sri_class_ev_t;

  typedef struct packed {
    logic [7:0] osc_q;
    logic [7:0] rstc_q;
  } sri_cond_t;

  typedef struct packed {
    logic by_int;
    logic high_prio;
    logic high_global_int_enable;
    logic low_global_int_enable;
    logic [7:0] src;
  } sri_wake_t;

endpackage

// >>> verif/sri_sfr_init_sva.sv
// Purpose: Port-level checks for the reset-class register bank
// Assumes: One clock domain with a synchronous active-low reset
// Notes: Bound to every instance of the bank
`timescale 1ns/1ps
`default_nettype none

module sri_sfr_init_chk (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire sri_pkg::sri_ahb_req_t i_ahb,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire sri_pkg::sri_class_ev_t i_class_ev,
  input wire sri_pkg::sri_wake_t i_wake,
  input wire logic i_osc_frees_pins,
  input wire logic o_pc_load,
  input wire logic [20:0] o_pc_vector,
  input wire logic [7:0] o_port_a_latch,
  input wire logic [7:0] o_port_a_direction
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // ----------------------------------------------------------------
  // Wake decode
  // ----------------------------------------------------------------
  logic wake_int;
  logic vec_hi;
  logic vec_lo;
  assign wake_int = i_class_ev.valid && i_class_ev.cls == sri_pkg::SRI_CLS_WAKE && i_wake.by_int;
  assign vec_hi = wake_int && i_wake.high_prio && i_wake.high_global_int_enable;
  assign vec_lo = wake_int && !i_wake.high_prio && i_wake.low_global_int_enable;

  sequence rd_req;
    i_ahb.hsel && i_ahb.htrans[1] && !i_ahb.hwrite && i_ahb.hready;
  endsequence
  sequence one_wait;
    !o_hreadyout ##1 o_hreadyout;
  endsequence

  AST_PC_HIGH: assert property (vec_hi |=> o_pc_load && o_pc_vector == 21'h000008)
    else $error("high wake did not vector");
  AST_PC_LOW: assert property (vec_lo |=> o_pc_load && o_pc_vector == 21'h000018)
    else $error("low wake did not vector");
  AST_PC_NONE: assert property (!(vec_hi || vec_lo) |=> !o_pc_load)
    else $error("vector load without cause");
  AST_RD_WAIT: assert property (rd_req |=> one_wait)
    else $error("read wait state wrong");
  AST_WR_NOWAIT: assert property (i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hwrite && i_ahb.hready |=> o_hreadyout)
    else $error("write stalled");
  AST_OKAY: assert property (o_hresp == 1'h0)
    else $error("response not okay");
  AST_RD_UPPER: assert property (o_hreadyout |-> o_hrdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  AST_PA_HI_OFF: assert property (!i_osc_frees_pins && $past(i_osc_frees_pins) == 1'h0 |->
    o_port_a_latch[7:6] == 2'h0 && o_port_a_direction[7:6] == 2'h0)
    else $error("port high bits shown while disabled");
endmodule

bind sri_sfr_init sri_sfr_init_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ahb(i_ahb),
  .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_class_ev(i_class_ev),
  .i_wake(i_wake), .i_osc_frees_pins(i_osc_frees_pins), .o_pc_load(o_pc_load), .o_pc_vector(o_pc_vector),
  .o_port_a_latch(o_port_a_latch), .o_port_a_direction(o_port_a_direction));

`default_nettype wire

// >>> verif/test_sfr_reset_initialization.sv
// Purpose: Self-checking bench for the reset-class register bank
// Assumes: 40 MHz clock, reset held three cycles, single-word AHB-Lite transfers
// Notes: Undefined power-on contents are expected as zero, as the bank loads them
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

module test_sfr_reset_initialization;
  typedef logic [7:0] sri_exp_tab_t [24];
  localparam sri_exp_tab_t IMPL_TAB = '{8'h0F, 8'hFF, 8'h0F, 8'h0F, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hBF, 8'h01, 8'hDF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam sri_exp_tab_t POR_TAB = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h48,
    8'h05, 8'h00, 8'h5C, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam sri_exp_tab_t RST_TAB = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h1F, 8'h00, 8'hFF, 8'hFF, 8'h48,
    8'h05, 8'h00, 8'h5F, 8'hFF, 8'hFF, 8'hBF, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam sri_exp_tab_t WAKE_TAB = '{8'h0F, 8'hFF, 8'h0F, 8'h0F, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFD,
    8'hBF, 8'h01, 8'h93, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  sri_pkg::sri_ahb_req_t ahb = '0;
  sri_pkg::sri_ahb_req_t ahb_in;
  sri_pkg::sri_class_ev_t cev = '0;
  sri_pkg::sri_cond_t cond = '{osc_q: 8'h08, rstc_q: 8'h5C};
  sri_pkg::sri_wake_t wake = '0;
  logic [20:0] pc = 21'h000000;
  logic frees = 1'h0;
  logic [7:0] pins = 8'hFF;
  logic [31:0] hrdata;
  logic hreadyout, irq, pc_load, hi_en;
  logic [20:0] pc_vec;
  logic [7:0] pa_lat, pa_dir;
  int mismatches = 0;
  int compares = 0;

  sri_sfr_init uut (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_ahb(ahb_in), .o_hrdata(hrdata),
    .o_hreadyout(hreadyout), .o_hresp(), .i_class_ev(cev), .i_cond(cond), .i_wake(wake), .i_pc(pc),
    .i_osc_frees_pins(frees), .i_port_a_pins(pins), .o_irq(irq), .o_pc_load(pc_load), .o_pc_vector(pc_vec),
    .o_port_a_latch(pa_lat), .o_port_a_direction(pa_dir), .o_port_a_hi_en(hi_en));

  always #12.5 ref_clk = ~ref_clk;

  // Single slave, so its readiness is the bus readiness
  always_comb begin
    ahb_in = ahb;
    ahb_in.hready = hreadyout;
  end

  // ----------------------------------------------------------------
  // Bus and event drivers
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [6:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    ahb.hsel <= 1'h1;
    ahb.htrans <= 2'h2;
    ahb.hwrite <= wr;
    ahb.haddr <= {23'h000000, idx, 2'h0};
    // No wait limit here: only the watchdog may end a stalled transfer
    do begin
      @(posedge ref_clk);
    end while (hreadyout !== 1'h1);
    ahb.hsel <= 1'h0;
    ahb.htrans <= 2'h0;
    ahb.hwdata <= {24'h000000, wd};
    do begin
      @(posedge ref_clk);
    end while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask

  task automatic pulse(input sri_pkg::sri_cls_t c);
    cev <= '{valid: 1'h1, cls: c};
    @(posedge ref_clk);
    cev.valid <= 1'h0;
    @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_class(input logic fill, input logic fire, input sri_pkg::sri_cls_t c, input sri_exp_tab_t tab);
    logic [31:0] rd;
    for (int i = 0; i < 24; i++) begin
      if (fill) xfer(1'h1, 7'(i), 8'hFF, rd);
    end
    if (fire) pulse(c);
    for (int i = 0; i < 24; i++) begin
      xfer(1'h0, 7'(i), 8'h00, rd);
      `CHK("register", tab[i], rd[7:0])
    end
  endtask

  task automatic t_vec(input logic hp, input logic eh, input logic el, input logic [20:0] vec);
    logic [31:0] rd;
    logic ld;
    xfer(1'h1, sri_pkg::SRI_IDX_STKP, 8'h05, rd);
    xfer(1'h1, sri_pkg::SRI_IDX_INT_FLAGS, 8'h00, rd);
    wake <= '{by_int: 1'h1, high_prio: hp, high_global_int_enable: eh, low_global_int_enable: el, src: 8'h20};
    pc <= 21'h1ABCDE;
    cev <= '{valid: 1'h1, cls: sri_pkg::SRI_CLS_WAKE};
    @(posedge ref_clk);
    cev.valid <= 1'h0;
    @(posedge ref_clk);
    ld = pc_load;
    `CHK("pc load", (vec != 21'h000000), ld)
    if (vec != 21'h000000) begin
      `CHK("pc vector", vec, pc_vec)
      xfer(1'h0, sri_pkg::SRI_IDX_TOS_UPPER, 8'h00, rd);
      `CHK("stack top upper", 8'h1A, rd[7:0])
      xfer(1'h0, sri_pkg::SRI_IDX_TOS_HIGH, 8'h00, rd);
      `CHK("stack top high", 8'hBC, rd[7:0])
      xfer(1'h0, sri_pkg::SRI_IDX_TOS_LOW, 8'h00, rd);
      `CHK("stack top low", 8'hDE, rd[7:0])
    end
    xfer(1'h0, sri_pkg::SRI_IDX_STKP, 8'h00, rd);
    `CHK("stack pointer", (vec != 21'h000000) ? 8'h06 : 8'h05, rd[7:0])
    xfer(1'h0, sri_pkg::SRI_IDX_INT_FLAGS, 8'h00, rd);
    `CHK("wake flag", 1'h1, rd[5])
  endtask

  task automatic t_irq();
    logic [31:0] rd;
    xfer(1'h1, sri_pkg::SRI_IDX_IRQ_MASK, 8'h00, rd);
    xfer(1'h0, sri_pkg::SRI_IDX_IRQ_STATUS, 8'h00, rd);
    pulse(sri_pkg::SRI_CLS_WAKE);
    repeat (2) @(posedge ref_clk);
    `CHK("irq masked", 1'h0, irq)
    xfer(1'h1, sri_pkg::SRI_IDX_IRQ_MASK, 8'h04, rd);
    repeat (2) @(posedge ref_clk);
    `CHK("irq raised", 1'h1, irq)
    xfer(1'h0, sri_pkg::SRI_IDX_IRQ_STATUS, 8'h00, rd);
    `CHK("irq status", 8'h04, rd[7:0])
    repeat (2) @(posedge ref_clk);
    `CHK("irq cleared", 1'h0, irq)
  endtask

  task automatic t_port();
    logic [31:0] rd;
    frees <= 1'h0;
    xfer(1'h1, sri_pkg::SRI_IDX_PA_LATCH, 8'hFF, rd);
    xfer(1'h0, sri_pkg::SRI_IDX_PA_LATCH, 8'h00, rd);
    `CHK("latch read off", 8'h3F, rd[7:0])
    `CHK("latch out off", 8'h3F, pa_lat)
    xfer(1'h0, sri_pkg::SRI_IDX_PA_DIR, 8'h00, rd);
    `CHK("direction off", 8'h3F, rd[7:0])
    xfer(1'h0, sri_pkg::SRI_IDX_PA_PINS, 8'h00, rd);
    `CHK("pins off", 8'h3F, rd[7:0])
    frees <= 1'h1;
    xfer(1'h1, sri_pkg::SRI_IDX_PA_LATCH, 8'hC5, rd);
    xfer(1'h0, sri_pkg::SRI_IDX_PA_LATCH, 8'h00, rd);
    `CHK("latch read on", 8'hC5, rd[7:0])
    `CHK("high pins on", 1'h1, hi_en)
    `CHK("direction on", 8'hFF, pa_dir)
    xfer(1'h1, 7'h30, 8'hA5, rd);
    xfer(1'h0, 7'h30, 8'h00, rd);
    `CHK("unmapped", 32'h00000000, rd)
  endtask

  task automatic complete_run();
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    ahb.hsize <= 3'h2;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'h1;
    t_class(1'h0, 1'h0, sri_pkg::SRI_CLS_POR, POR_TAB);
    t_class(1'h1, 1'h0, sri_pkg::SRI_CLS_POR, IMPL_TAB);
    t_class(1'h1, 1'h1, sri_pkg::SRI_CLS_POR, POR_TAB);
    t_class(1'h1, 1'h1, sri_pkg::SRI_CLS_RST, RST_TAB);
    cond <= '0;
    t_class(1'h1, 1'h1, sri_pkg::SRI_CLS_WAKE, WAKE_TAB);
    cond <= '{osc_q: 8'h08, rstc_q: 8'h5C};
    t_vec(1'h1, 1'h1, 1'h0, 21'h000008);
    t_vec(1'h0, 1'h0, 1'h1, 21'h000018);
    t_vec(1'h0, 1'h0, 1'h0, 21'h000000);
    t_irq();
    t_port();
    complete_run();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    complete_run();
  end
endmodule

`default_nettype wire
